// ---- wdtu_pkg.sv ----
// Package with the register map, field layout, reset values and timing constants of the watchdog timeout unit.
`default_nettype none
package wdtu_pkg;
  // Byte address of the single control register.
  localparam logic [7:0] WDTU_CTL_OFS = 8'hC0;
  // Field positions inside the control register.
  localparam int WDTU_PRE_MSB = 7;
  localparam int WDTU_PRE_LSB = 4;
  localparam int WDTU_ACT_BIT = 3;
  localparam int WDTU_STAT_BIT = 2;
  localparam int WDTU_ARM_BIT = 1;
  localparam int WDTU_UNLOCK_BIT = 0;
  // Power-on value of the control register: prescale 1, disarmed, flags clear.
  localparam logic [7:0] WDTU_CTL_RST = 8'h10;
  localparam logic [3:0] WDTU_PRE_RST = 4'h1;
  localparam logic [3:0] WDTU_PRE_IMMEDIATE = 4'h8;
  // Timing: core clock period and watchdog timebase.
  localparam int WDTU_CLK_PERIOD_NS = 50;
  localparam int WDTU_CLK_HZ = 1000000000 / WDTU_CLK_PERIOD_NS;
  localparam int WDTU_WD_CLK_HZ = 32768;
  localparam int WDTU_BASE_TICKS = 512;
  localparam int WDTU_CNT_W = 16;
  // Bus encodings.
  localparam logic [1:0] WDTU_HTRANS_NONSEQ = 2'h2;
  localparam logic WDTU_HRESP_OKAY = 1'h0;
endpackage : wdtu_pkg
`default_nettype wire

// ---- wdtu_tick.sv ----
// Fractional divider that makes one-cycle ticks of the watchdog timebase from the core clock.
`timescale 1ns/100ps
`default_nettype none
module wdtu_tick import wdtu_pkg::*; #(
  parameter int CLK_HZ = WDTU_CLK_HZ,
  parameter int TICK_HZ = WDTU_WD_CLK_HZ
) (
  // Clock and control
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Timebase tick
  output logic tick
);
  localparam logic [25:0] STEP = 26'(TICK_HZ);
  localparam logic [25:0] WRAP = 26'(CLK_HZ);

  logic [25:0] acc_q;
  logic [25:0] acc_sum;
  logic wrap_now;
  logic tick_q;

  // A phase accumulator keeps the long-run rate exact without a PLL; the jitter is one core cycle.
  assign acc_sum = acc_q + STEP;
  assign wrap_now = acc_sum >= WRAP;
  assign tick = tick_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 26'h0;
      tick_q <= 1'b0;
    end else if (ce) begin
      acc_q <= wrap_now ? acc_sum - WRAP : acc_sum;
      tick_q <= wrap_now;
    end
  end
endmodule // wdtu_tick
`default_nettype wire

// ---- wdtu_cnt.sv ----
// Timeout counter with synchronous clear and increment.
`timescale 1ns/100ps
`default_nettype none
module wdtu_cnt #(
  parameter int WIDTH = 16
) (
  // Clock and control
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Counting
  input wire logic clr,
  input wire logic inc,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] count_q;

  assign count = count_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
    end else if (ce) begin
      if (clr) begin
        count_q <= '0;
      end else if (inc) begin
        count_q <= count_q + WIDTH'(1);
      end
    end
  end
endmodule // wdtu_cnt
`default_nettype wire

// ---- wdtu_top.sv ----
// Watchdog timeout unit with its locked control register on an AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - A 16-bit counter advances on each 32.768 kHz timebase tick while armed with prescale 0 to 7, and is held clear otherwise.
// - With the arm bit clear the watchdog neither resets nor interrupts.
// - Armed watchdog must be re-armed by writing 1 before timeout, else it fires.
// - Prescale 0 to 7 gives 2 to the prescale times 512 timebase periods.
// - Codes 0 to 7 give 15.6 to 2000 ms; code 8 resets immediately.
// - Action select chooses reset when 0, interrupt when 1.
// - Every timeout sets the sticky status flag.
// - Status clears only by writing 0 or external reset, not watchdog reset.
// - Arm bit clears on a written 0 or on a timeout reset.
// - Control writes are accepted only as the second write of the unlock pair.
// - The unlock write must be the very next transfer's predecessor; others are rejected.
// - After power-on the control register holds 10H.
module wdtu_top import wdtu_pkg::*; #(
  parameter int CNT_W = WDTU_CNT_W,
  parameter int CLK_HZ = WDTU_CLK_HZ,
  parameter int TICK_HZ = WDTU_WD_CLK_HZ
) (
  // Clock, reset and clock enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Watchdog actions
  output logic wd_sys_reset,
  output logic wd_irq
);
  // Control register fields.
  logic [3:0] pre_q;
  logic act_q;
  logic status_q;
  logic arm_q;
  logic unlock_q;
  // Bus data-phase state.
  logic wr_pend_q;
  logic rd_pend_q;
  logic ctl_sel_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  // Action outputs.
  logic rst_q;
  logic irq_q;

  logic tick;
  logic [CNT_W-1:0] cnt;
  logic [31:0] lim_wide;
  logic [CNT_W-1:0] limit;

  // Address-phase decode.
  wire addr_take = hsel && htrans[1] && hready;
  wire ctl_hit = haddr[7:0] == WDTU_CTL_OFS;
  wire [7:0] ctl_rd = {pre_q, act_q, status_q, arm_q, unlock_q};
  // Data-phase decode; the slave has no wait states, so every data phase ends at the next edge.
  wire ctl_wr = wr_pend_q && ctl_sel_q;
  wire any_dphase = wr_pend_q || rd_pend_q;
  wire unlock_take = ctl_wr && !unlock_q && hwdata[WDTU_UNLOCK_BIT];
  wire accept = ctl_wr && unlock_q;
  wire clr_status = accept && !hwdata[WDTU_STAT_BIT];
  wire rearm = accept && hwdata[WDTU_ARM_BIT];

  // Timeout decode.
  wire pre_normal = !pre_q[3];
  wire pre_immed = pre_q == WDTU_PRE_IMMEDIATE;
  wire tmo_normal = arm_q && pre_normal && tick && (cnt == limit);
  wire tmo_immed = arm_q && pre_immed;
  wire timeout_ev = tmo_normal || tmo_immed;
  wire do_reset = timeout_ev && (tmo_immed || !act_q);
  wire do_irq = tmo_normal && act_q;
  wire cnt_clr = !arm_q || rearm || timeout_ev || !pre_normal;
  wire cnt_inc = arm_q && tick;

  // Timeout is the last count of 512 << prescale timebase periods.
  assign lim_wide = (32'(WDTU_BASE_TICKS) << pre_q[2:0]) - 32'h1;
  assign limit = lim_wide[CNT_W-1:0];

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = WDTU_HRESP_OKAY;
  assign wd_sys_reset = rst_q;
  assign wd_irq = irq_q;

  wdtu_tick #(
    .CLK_HZ(CLK_HZ),
    .TICK_HZ(TICK_HZ)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .tick(tick)
  );

  wdtu_cnt #(
    .WIDTH(CNT_W)
  ) u_cnt (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .clr(cnt_clr),
    .inc(cnt_inc),
    .count(cnt)
  );

  // Bus slave: read data are captured in the address phase and stand through the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ctl_sel_q <= 1'b0;
      hrdata_q <= 32'h0;
      hreadyout_q <= 1'b1;
    end else if (ce) begin
      wr_pend_q <= addr_take && hwrite;
      rd_pend_q <= addr_take && !hwrite;
      ctl_sel_q <= addr_take && ctl_hit;
      hrdata_q <= (addr_take && !hwrite && ctl_hit) ? {24'h0, ctl_rd} : 32'h0;
      hreadyout_q <= 1'b1;
    end
  end

  // The unlock is consumed by whatever transfer comes next, so a stray access in between re-locks.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unlock_q <= 1'b0;
    end else if (ce && any_dphase) begin
      unlock_q <= unlock_take;
    end
  end

  // Control fields; only the second write of the unlock pair lands.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= WDTU_PRE_RST;
      act_q <= 1'b0;
    end else if (ce && accept) begin
      pre_q <= hwdata[WDTU_PRE_MSB:WDTU_PRE_LSB];
      act_q <= hwdata[WDTU_ACT_BIT];
    end
  end

  // A timeout reset wins over a same-cycle re-arm, since the system is going down anyway.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_q <= 1'b0;
    end else if (ce) begin
      if (do_reset) begin
        arm_q <= 1'b0;
      end else if (accept) begin
        arm_q <= hwdata[WDTU_ARM_BIT];
      end
    end
  end

  // The status flag only falls to a written 0 or to hresetn; a new timeout beats the clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 1'b0;
    end else if (ce) begin
      if (timeout_ev) begin
        status_q <= 1'b1;
      end else if (clr_status) begin
        status_q <= 1'b0;
      end
    end
  end

  // The reset request is a pulse; the interrupt request is a level that software drops with the status flag.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (ce) begin
      rst_q <= do_reset;
      if (do_irq) begin
        irq_q <= 1'b1;
      end else if (clr_status) begin
        irq_q <= 1'b0;
      end
    end
  end

  // Idle cycles may sit between the unlock and the control write, so only the landing write is matched.
  sequence s_unlock_pair;
    unlock_q && wr_pend_q && ctl_sel_q && ce;
  endsequence

  sequence s_tick_then_quiet;
    tick ##1 !tick [*8];
  endsequence

  AST_TICK_SPACING: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && ce |-> s_tick_then_quiet)
    else $error("Timebase ticks closer than the divider allows.");

  AST_DISARMED_SILENT: assert property (@(posedge hclk) disable iff (!hresetn)
    !arm_q && ce |=> !rst_q && !$rose(irq_q))
    else $error("Disarmed watchdog raised an action.");

  AST_TIMEOUT_AT_LIMIT: assert property (@(posedge hclk) disable iff (!hresetn)
    tmo_normal |-> cnt == CNT_W'(lim_wide) && cnt >= CNT_W'(16'h01FF))
    else $error("Timeout fired away from the prescale limit.");

  AST_IMMEDIATE_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
    arm_q && pre_q == WDTU_PRE_IMMEDIATE && ce |=> rst_q && !arm_q)
    else $error("Immediate-reset code did not reset at once.");

  AST_RESET_ACTION: assert property (@(posedge hclk) disable iff (!hresetn)
    tmo_normal && !act_q && ce |=> rst_q && !arm_q && status_q ##1 !rst_q || !ce)
    else $error("Reset-action timeout did not pulse reset and disarm.");

  AST_IRQ_ACTION: assert property (@(posedge hclk) disable iff (!hresetn)
    tmo_normal && act_q && ce |=> irq_q && !rst_q && status_q && arm_q)
    else $error("Interrupt-action timeout did not raise only the interrupt.");

  AST_STATUS_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
    status_q && !clr_status |=> status_q)
    else $error("Status flag fell without a written 0.");

  AST_LOCKED_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    ctl_wr && !unlock_q && !do_reset |=> $stable(pre_q) && $stable(act_q) && $stable(arm_q))
    else $error("Locked control write changed the register.");

  AST_UNLOCK_PAIR: assert property (@(posedge hclk) disable iff (!hresetn)
    s_unlock_pair |=> pre_q == $past(hwdata[WDTU_PRE_MSB:WDTU_PRE_LSB]) && !unlock_q)
    else $error("Unlock pair did not land the second write.");

  AST_REARM_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn)
    rearm && ce && !do_reset |=> cnt == '0 && arm_q)
    else $error("Re-arm did not restart the timeout count.");

  AST_STATUS_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    timeout_ev && ce |=> status_q)
    else $error("Timeout did not set the status flag.");

  AST_REARM_HOLDS_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    rearm && ce && !hwdata[WDTU_PRE_MSB] && !do_reset |=> !rst_q [*3])
    else $error("Watchdog fired right after a re-arm.");

endmodule // wdtu_top
`default_nettype wire

// ---- wdtu_tb.sv ----
// Self-checking testbench for the watchdog timeout unit over its AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import wdtu_pkg::*;
  typedef struct packed {
    logic unlk;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [31:0] exp;
  } wdtu_row_t;
  // A fast timebase (one tick every 20 cycles) keeps full timeouts within a short run.
  localparam int TB_TICK_HZ = 1000000;
  localparam int TB_LIMIT = 80000;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, wd_sys_reset, wd_irq;
  int fail_count, comparisons, cycles;
  logic [31:0] rd;
  logic quiet;
  wdtu_row_t rows [5];
  wdtu_top #(.CLK_HZ(WDTU_CLK_HZ), .TICK_HZ(TB_TICK_HZ)) u_wdtu_top (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wd_sys_reset(wd_sys_reset), .wd_irq(wd_irq));
  initial hclk = 1'b0;
  always #(WDTU_CLK_PERIOD_NS / 2) hclk = ~hclk;
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The bench stands in for the master: address phase held until hready, then the data phase.
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, addr};
    hwrite <= wr;
    htrans <= WDTU_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? wdata : 32'h00000000;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h00000000, WDTU_HRESP_OKAY}, {31'h00000000, hresp});
  endtask
  task automatic ctl_write(input logic [7:0] data);
    bus(1'b1, WDTU_CTL_OFS, 32'h00000001);
    bus(1'b1, WDTU_CTL_OFS, {24'h000000, data});
  endtask
  task automatic ctl_read(input string name, input logic [31:0] exp);
    bus(1'b0, WDTU_CTL_OFS, 32'h00000000);
    chk(name, exp, rd);
  endtask
  // Waits for the chosen action output and checks the delay lies inside the timeout window.
  task automatic wait_act(input logic irq, input int lo, input int hi);
    int n;
    n = 0;
    while (((irq ? wd_irq : wd_sys_reset) !== 1'b1) && n < hi) begin
      @(posedge hclk);
      #1;
      n++;
      if ((irq ? wd_sys_reset : wd_irq) !== 1'b0) begin
        chk("other action", 32'h0, 32'h1);
      end
    end
    chk("action in window", 32'h1, {31'h0, n >= lo && n < hi});
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == TB_LIMIT) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    cycles = 0;
    fail_count = 0;
    comparisons = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rows[0] = '{1'b1, 8'hC0, 8'h20, 32'h00000020};
    rows[1] = '{1'b0, 8'hC0, 8'h40, 32'h00000020};
    rows[2] = '{1'b1, 8'hC4, 8'h40, 32'h00000000};
    rows[3] = '{1'b0, 8'hC0, 8'h40, 32'h00000020};
    rows[4] = '{1'b1, 8'hC0, 8'h90, 32'h00000090};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ctl_read("ctl after reset", {24'h000000, WDTU_CTL_RST});
    foreach (rows[i]) begin
      if (rows[i].unlk) begin
        bus(1'b1, WDTU_CTL_OFS, 32'h00000001);
      end
      bus(1'b1, rows[i].addr, {24'h000000, rows[i].wdata});
      bus(1'b0, rows[i].addr, 32'h00000000);
      chk("row readback", rows[i].exp, rd);
    end
    // Armed at the shortest timeout, re-armed midway: the full period restarts from the re-arm.
    ctl_write(8'h02);
    repeat (6000) @(posedge hclk);
    ctl_write(8'h02);
    wait_act(1'b0, 10200, 10260);
    @(posedge hclk);
    #1;
    chk("reset pulse width", 32'h0, {31'h0, wd_sys_reset});
    ctl_read("ctl after timeout reset", 32'h00000004);
    ctl_write(8'h0E);
    wait_act(1'b1, 10200, 10260);
    ctl_read("ctl after irq timeout", 32'h0000000E);
    chk("irq level", 32'h1, {31'h0, wd_irq});
    ctl_write(8'h08);
    ctl_read("ctl disarmed", 32'h00000008);
    chk("irq dropped", 32'h0, {31'h0, wd_irq});
    quiet = 1'b1;
    repeat (11000) begin
      @(posedge hclk);
      #1;
      if (wd_irq !== 1'b0 || wd_sys_reset !== 1'b0) begin
        quiet = 1'b0;
      end
    end
    chk("disarmed quiet", 32'h1, {31'h0, quiet});
    ctl_write(8'h82);
    wait_act(1'b0, 0, 5);
    ctl_read("ctl after immediate", 32'h00000084);
    // Besides a written 0, only the external reset clears the sticky status; the watchdog reset leaves it set.
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ctl_read("ctl after hw reset", {24'h000000, WDTU_CTL_RST});
    final_report();
  end
endmodule // tb
`default_nettype wire
